// file: hdl/rrc_defs.svh
// Constants of the command unit
// =====================================================================
// How it works
// - Fault selector upper byte 00..09 picks newest..tenth record.
// - A selector upper byte of 0A..FF yields a zero record.
// - PID deviation is signed, -10000..10000.
// - PID words apply only when enabled; bad values are dropped.
// - Source 3 or 5 in torque control makes the word a command.
// - An accepted torque word updates both torque parameters.
// - Source 3 or 5 with limit method 2 outside torque control makes it an absolute limit.
// - A torque word out of the source's range is ignored.
// - Execute runs primary then slots a..e in order, then flags done.
// - Extra slots holding FFFF are skipped; primary always runs.
// - Instruction word upper byte is extended setting, lower the code.
// - Sign selection 1 makes set frequency signed; negative reverses.
// - Either request writes the same values; only a nonvolatile one pulses the commit outputs.
`ifndef RRC_DEFS_SVH
`define RRC_DEFS_SVH

// =====================================================================
// Fault record selection
`define RRC_FAULT_LAST    8'h09
// Instruction slots
`define RRC_SKIP_CODE     16'hFFFF
`define RRC_LAST_SLOT     3'h5
// Ranges as 17-bit two's complement
`define RRC_PID_MIN       17'h00000
`define RRC_PID_MAX       17'h02710
`define RRC_PIDE_MIN      17'h1D8F0
`define RRC_FREQ_MIN      17'h00000
`define RRC_FREQ_MAX      17'h0E678
`define RRC_FREQS_MIN     17'h18000
`define RRC_FREQS_MAX     17'h07FFF
`define RRC_TQ3_MIN       17'h1F060
`define RRC_TQ3_MAX       17'h00FA0
`define RRC_TQ5_MIN       17'h18001
`define RRC_TQ5_MAX       17'h07FFF
`define RRC_ZERO17        17'h00000
// Selection codes
`define RRC_TQ_SRC_A      8'h03
`define RRC_TQ_SRC_B      8'h05
`define RRC_TQ_LIM_LINK   8'h02
`define RRC_FSIGN_ON      8'h01
`define RRC_PID_OFF       8'h00
`define RRC_PID_SEL_LINK  8'h05
// Reset values
`define RRC_RST_WORD      16'h0000

`endif

// file: hdl/rrc_pkg.sv
// Types of the command unit
`default_nettype none
package rrc_pkg;
  // =====================================================================
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    RRC_IDLE  = 4'h1,
    RRC_ISSUE = 4'h2,
    RRC_WAIT  = 4'h4,
    RRC_DONE  = 4'h8
  } rrc_seq_t;
  typedef logic [15:0] rrc_word_t;
endpackage : rrc_pkg
`default_nettype wire

// file: hdl/rrc_range_check.sv
// Inclusive range check, signed or unsigned
`default_nettype none
module rrc_range_check (
  input  wire logic [15:0] word,
  input  wire logic        is_signed,
  input  wire logic [16:0] lo,
  input  wire logic [16:0] hi,
  output logic             in_range
);
  // =====================================================================
  // Widen by one bit so both encodings compare as signed
  logic signed [16:0] val;
  assign val      = {is_signed & word[15], word};
  assign in_range = (val >= $signed(lo)) && (val <= $signed(hi));
endmodule : rrc_range_check
`default_nettype wire

// file: hdl/rrc_top.sv
// Command unit: master-written words and instruction batch
`include "rrc_defs.svh"
`default_nettype none
module rrc_top #(
  parameter int SEL_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // Remote words written cyclically by the master
  input  wire logic [15:0]      fault_record_selector,
  input  wire logic [15:0]      pid_target_value,
  input  wire logic [15:0]      pid_feedback_value,
  input  wire logic [15:0]      pid_error_value,
  input  wire logic [15:0]      torque_command_or_limit,
  input  wire logic [15:0]      set_frequency_word,
  input  wire logic [15:0]      primary_instruction_slot,
  input  wire logic [15:0]      primary_operand_slot,
  input  wire logic [15:0]      extra_instruction_slot_a,
  input  wire logic [15:0]      extra_operand_slot_a,
  input  wire logic [15:0]      extra_instruction_slot_b,
  input  wire logic [15:0]      extra_operand_slot_b,
  input  wire logic [15:0]      extra_instruction_slot_c,
  input  wire logic [15:0]      extra_operand_slot_c,
  input  wire logic [15:0]      extra_instruction_slot_d,
  input  wire logic [15:0]      extra_operand_slot_d,
  input  wire logic [15:0]      extra_instruction_slot_e,
  input  wire logic [15:0]      extra_operand_slot_e,
  // Handshake bits from the master
  input  wire logic             execute_request_bit,
  input  wire logic             volatile_write_request,
  input  wire logic             nonvolatile_write_request,
  // Device settings
  input  wire logic [SEL_W-1:0] torque_source_selection,
  input  wire logic [SEL_W-1:0] torque_limit_input_method,
  input  wire logic [SEL_W-1:0] frequency_sign_selection,
  input  wire logic [SEL_W-1:0] pid_action_selection,
  input  wire logic [SEL_W-1:0] pid_target_input_selection,
  input  wire logic [SEL_W-1:0] pid_feedback_input_selection,
  input  wire logic             torque_control_active,
  // Instruction executor handshake
  input  wire logic             instr_done,
  output logic                  instr_valid_q,
  output logic [7:0]            instr_code_q,
  output logic [7:0]            instr_ext_q,
  output logic [15:0]           instr_operand_q,
  output logic [2:0]            instr_slot_q,
  output logic                  execution_complete_flag,
  // Fault history selection
  output logic [3:0]            fault_index_q,
  output logic                  fault_zero_q,
  // PID inputs
  output logic [15:0]           pid_target_q,
  output logic [15:0]           pid_feedback_q,
  output logic [15:0]           pid_error_q,
  // Torque parameters
  output logic [15:0]           torque_value_ram_param,
  output logic [15:0]           torque_value_eeprom_param,
  output logic                  torque_is_limit_q,
  output logic                  torque_nv_commit_q,
  // Set frequency
  output logic [15:0]           freq_magnitude_q,
  output logic                  freq_reverse_q,
  output logic                  freq_nv_commit_q
);

  // =====================================================================
  // Write request edges
  logic vol_q;
  logic nv_q;
  logic vol_rise;
  logic nv_rise;
  logic wr_pulse;

  // Only a fresh request writes; a held bit does not repeat the store
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vol_q <= 1'b0;
      nv_q  <= 1'b0;
    end else begin
      vol_q <= volatile_write_request;
      nv_q  <= nonvolatile_write_request;
    end
  end

  assign vol_rise = volatile_write_request & ~vol_q;
  assign nv_rise  = nonvolatile_write_request & ~nv_q;
  assign wr_pulse = vol_rise | nv_rise;

  // =====================================================================
  // Fault history selection
  logic [7:0] fault_sel;
  assign fault_sel = fault_record_selector[15:8];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_index_q <= 4'h0;
      fault_zero_q  <= 1'b0;
    end else if (fault_sel > `RRC_FAULT_LAST) begin
      fault_index_q <= 4'h0;
      fault_zero_q  <= 1'b1;
    end else begin
      fault_index_q <= fault_sel[3:0];
      fault_zero_q  <= 1'b0;
    end
  end

  // =====================================================================
  // Torque word meaning
  logic tq_src_ok;
  logic tq_cmd_mode;
  logic tq_lim_mode;
  logic tq_src5;
  logic fsign_on;

  assign tq_src5     = torque_source_selection == `RRC_TQ_SRC_B;
  assign tq_src_ok   = tq_src5 ||
                       torque_source_selection == `RRC_TQ_SRC_A;
  assign tq_cmd_mode = tq_src_ok & torque_control_active;
  assign tq_lim_mode = tq_src_ok & ~torque_control_active &
                       (torque_limit_input_method == `RRC_TQ_LIM_LINK);
  assign fsign_on    = frequency_sign_selection == `RRC_FSIGN_ON;

  // =====================================================================
  // Range checks: 0 target, 1 feedback, 2 deviation, 3 torque, 4 freq
  localparam int NCHK = 5;
  logic [15:0] chk_word [NCHK];
  logic        chk_sgn  [NCHK];
  logic [16:0] chk_lo   [NCHK];
  logic [16:0] chk_hi   [NCHK];
  logic        chk_ok   [NCHK];
  logic [16:0] tq_max;

  // A limit is a magnitude, so it checks unsigned from zero
  assign tq_max = tq_src5 ? `RRC_TQ5_MAX : `RRC_TQ3_MAX;

  always_comb begin
    chk_word[0] = pid_target_value;
    chk_sgn[0]  = 1'b0;
    chk_lo[0]   = `RRC_PID_MIN;
    chk_hi[0]   = `RRC_PID_MAX;
    chk_word[1] = pid_feedback_value;
    chk_sgn[1]  = 1'b0;
    chk_lo[1]   = `RRC_PID_MIN;
    chk_hi[1]   = `RRC_PID_MAX;
    chk_word[2] = pid_error_value;
    chk_sgn[2]  = 1'b1;
    chk_lo[2]   = `RRC_PIDE_MIN;
    chk_hi[2]   = `RRC_PID_MAX;
    chk_word[3] = torque_command_or_limit;
    chk_sgn[3]  = ~tq_lim_mode;
    chk_lo[3]   = tq_lim_mode ? `RRC_ZERO17 :
                  (tq_src5 ? `RRC_TQ5_MIN : `RRC_TQ3_MIN);
    chk_hi[3]   = tq_max;
    chk_word[4] = set_frequency_word;
    chk_sgn[4]  = fsign_on;
    chk_lo[4]   = fsign_on ? `RRC_FREQS_MIN : `RRC_FREQ_MIN;
    chk_hi[4]   = fsign_on ? `RRC_FREQS_MAX : `RRC_FREQ_MAX;
  end

  for (genvar g = 0; g < NCHK; g++) begin : g_chk
    rrc_range_check u_chk (
      .word      (chk_word[g]),
      .is_signed (chk_sgn[g]),
      .lo        (chk_lo[g]),
      .hi        (chk_hi[g]),
      .in_range  (chk_ok[g])
    );
  end

  // =====================================================================
  // PID inputs
  logic pid_on;
  logic tgt_en;
  logic fb_en;

  assign pid_on = pid_action_selection != `RRC_PID_OFF;
  assign tgt_en = pid_on &
                  (pid_target_input_selection == `RRC_PID_SEL_LINK);
  assign fb_en  = pid_on &
                  (pid_feedback_input_selection == `RRC_PID_SEL_LINK);

  // Disabled or out-of-range words leave the held value alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pid_target_q   <= `RRC_RST_WORD;
      pid_feedback_q <= `RRC_RST_WORD;
      pid_error_q    <= `RRC_RST_WORD;
    end else begin
      if (tgt_en && chk_ok[0]) begin
        pid_target_q <= pid_target_value;
      end
      if (fb_en && chk_ok[1]) begin
        pid_feedback_q <= pid_feedback_value;
      end
      if (tgt_en && fb_en && chk_ok[2]) begin
        pid_error_q <= pid_error_value;
      end
    end
  end

  // =====================================================================
  // Torque command or limit
  logic tq_take;
  assign tq_take = wr_pulse & (tq_cmd_mode | tq_lim_mode) & chk_ok[3];

  // Both parameters move together so they never disagree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      torque_value_ram_param    <= `RRC_RST_WORD;
      torque_value_eeprom_param <= `RRC_RST_WORD;
      torque_is_limit_q         <= 1'b0;
      torque_nv_commit_q        <= 1'b0;
    end else begin
      torque_nv_commit_q <= tq_take & nv_rise;
      if (tq_take) begin
        torque_value_ram_param    <= torque_command_or_limit;
        torque_value_eeprom_param <= torque_command_or_limit;
        torque_is_limit_q         <= tq_lim_mode;
      end
    end
  end

  // =====================================================================
  // Set frequency
  logic f_take;
  logic f_neg;
  assign f_take = wr_pulse & chk_ok[4];
  assign f_neg  = fsign_on & set_frequency_word[15];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      freq_magnitude_q <= `RRC_RST_WORD;
      freq_reverse_q   <= 1'b0;
      freq_nv_commit_q <= 1'b0;
    end else begin
      freq_nv_commit_q <= f_take & nv_rise;
      if (f_take) begin
        // Negating -32768 gives 32768, which still fits unsigned
        freq_magnitude_q <= f_neg ? 16'(~set_frequency_word + 16'h0001)
                                  : set_frequency_word;
        freq_reverse_q   <= f_neg;
      end
    end
  end

  // =====================================================================
  // Instruction batch
  localparam int NSLOT = 6;
  logic [15:0]       slot_code_in [NSLOT];
  logic [15:0]       slot_data_in [NSLOT];
  logic [15:0]       slot_code_q  [NSLOT];
  logic [15:0]       slot_data_q  [NSLOT];
  rrc_pkg::rrc_seq_t state_q;
  logic [2:0]        idx_q;
  logic              skip;
  logic              start;

  // Issue order is the array order
  always_comb begin
    slot_code_in[0] = primary_instruction_slot;
    slot_data_in[0] = primary_operand_slot;
    slot_code_in[1] = extra_instruction_slot_a;
    slot_data_in[1] = extra_operand_slot_a;
    slot_code_in[2] = extra_instruction_slot_b;
    slot_data_in[2] = extra_operand_slot_b;
    slot_code_in[3] = extra_instruction_slot_c;
    slot_data_in[3] = extra_operand_slot_c;
    slot_code_in[4] = extra_instruction_slot_d;
    slot_data_in[4] = extra_operand_slot_d;
    slot_code_in[5] = extra_instruction_slot_e;
    slot_data_in[5] = extra_operand_slot_e;
  end

  assign start = (state_q == rrc_pkg::RRC_IDLE) & execute_request_bit;
  assign skip  = (idx_q != 3'h0) &&
                 (slot_code_q[idx_q] == `RRC_SKIP_CODE);

  // Snapshot at start so master rewrites mid-batch cannot tear a pair
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_code_q[i] <= `RRC_RST_WORD;
        slot_data_q[i] <= `RRC_RST_WORD;
      end
    end else if (start) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_code_q[i] <= slot_code_in[i];
        slot_data_q[i] <= slot_data_in[i];
      end
    end
  end

  // Sequencer: one instruction outstanding at a time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= rrc_pkg::RRC_IDLE;
      idx_q   <= 3'h0;
    end else begin
      unique case (state_q)
        rrc_pkg::RRC_IDLE: begin
          idx_q <= 3'h0;
          if (execute_request_bit) begin
            state_q <= rrc_pkg::RRC_ISSUE;
          end
        end
        rrc_pkg::RRC_ISSUE: begin
          if (!skip) begin
            state_q <= rrc_pkg::RRC_WAIT;
          end else if (idx_q == `RRC_LAST_SLOT) begin
            state_q <= rrc_pkg::RRC_DONE;
          end else begin
            idx_q <= 3'(idx_q + 3'h1);
          end
        end
        rrc_pkg::RRC_WAIT: begin
          if (instr_done) begin
            if (idx_q == `RRC_LAST_SLOT) begin
              state_q <= rrc_pkg::RRC_DONE;
            end else begin
              idx_q   <= 3'(idx_q + 3'h1);
              state_q <= rrc_pkg::RRC_ISSUE;
            end
          end
        end
        rrc_pkg::RRC_DONE: begin
          if (!execute_request_bit) begin
            state_q <= rrc_pkg::RRC_IDLE;
          end
        end
      endcase
    end
  end

  // Issue to the executor, one-cycle valid
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      instr_valid_q   <= 1'b0;
      instr_code_q    <= 8'h00;
      instr_ext_q     <= 8'h00;
      instr_operand_q <= `RRC_RST_WORD;
      instr_slot_q    <= 3'h0;
    end else begin
      instr_valid_q <= (state_q == rrc_pkg::RRC_ISSUE) & ~skip;
      if ((state_q == rrc_pkg::RRC_ISSUE) && !skip) begin
        instr_code_q    <= slot_code_q[idx_q][7:0];
        instr_ext_q     <= slot_code_q[idx_q][15:8];
        instr_operand_q <= slot_data_q[idx_q];
        instr_slot_q    <= idx_q;
      end
    end
  end

  // Completion flag: high in the done state until execute drops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      execution_complete_flag <= 1'b0;
    end else begin
      unique case (state_q)
        rrc_pkg::RRC_ISSUE:
          execution_complete_flag <= skip && (idx_q == `RRC_LAST_SLOT);
        rrc_pkg::RRC_WAIT:
          execution_complete_flag <= instr_done &&
                                     (idx_q == `RRC_LAST_SLOT);
        rrc_pkg::RRC_DONE:
          execution_complete_flag <= execute_request_bit;
        rrc_pkg::RRC_IDLE:
          execution_complete_flag <= 1'b0;
      endcase
    end
  end

endmodule : rrc_top
`default_nettype wire

// file: testbench/rrc_exec_model.sv
// Behavioural instruction executor model
`default_nettype none
module rrc_exec_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       instr_valid_q,
  input  wire logic [3:0] resp_delay,
  output logic            instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // =====================================================================
  // Busy count; done never shares a cycle with its strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_q     <= 4'h0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (instr_valid_q) begin
        wait_q <= resp_delay;
      end else if (wait_q == 4'h1) begin
        wait_q     <= 4'h0;
        instr_done <= 1'b1;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : rrc_exec_model
`default_nettype wire

// file: testbench/rrc_top_checker.sv
// Concurrent checks on the unit's ports
`default_nettype none
module rrc_top_checker #(
  parameter int SEL_W = 8
) (
  input wire logic             clk_sys,
  input wire logic             rst_b,
  input wire logic [15:0]      fault_record_selector,
  input wire logic [15:0]      pid_target_value,
  input wire logic [15:0]      primary_instruction_slot,
  input wire logic             execute_request_bit,
  input wire logic             nonvolatile_write_request,
  input wire logic [SEL_W-1:0] torque_source_selection,
  input wire logic             instr_valid_q,
  input wire logic [7:0]       instr_code_q,
  input wire logic [7:0]       instr_ext_q,
  input wire logic [2:0]       instr_slot_q,
  input wire logic             execution_complete_flag,
  input wire logic [3:0]       fault_index_q,
  input wire logic             fault_zero_q,
  input wire logic [15:0]      pid_target_q,
  input wire logic [15:0]      torque_value_ram_param,
  input wire logic [15:0]      torque_value_eeprom_param,
  input wire logic             torque_nv_commit_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // Handshake steps
  sequence drop_s;
    execution_complete_flag && !execute_request_bit;
  endsequence
  sequence extra_issue_s;
    instr_valid_q && instr_slot_q != 3'h0;
  endsequence
  fault_zero_a: assert property ($past(rst_b) |-> fault_zero_q ==
    ($past(fault_record_selector[15:8]) > 8'h09)) else $error("fault zero");
  fault_index_a: assert property ($past(rst_b) &&
    $past(fault_record_selector[15:8]) < 8'h0A |->
    fault_index_q == $past(fault_record_selector[11:8])) else $error("index");
  pid_accept_a: assert property ($past(rst_b) && !$stable(pid_target_q)
    |-> pid_target_q == $past(pid_target_value) && pid_target_q <= 16'h2710)
    else $error("pid out of range");
  torque_pair_a: assert property (
    torque_value_ram_param == torque_value_eeprom_param)
    else $error("torque pair");
  torque_range_a: assert property (!$stable(torque_value_ram_param) &&
    torque_source_selection == 'h03 |-> $signed(torque_value_ram_param)
    >= -16'sd4000 && $signed(torque_value_ram_param) <= 16'sd4000)
    else $error("torque range");
  nv_commit_a: assert property (torque_nv_commit_q |->
    ($past(nonvolatile_write_request) || $past(nonvolatile_write_request, 2))
    ##1 !torque_nv_commit_q) else $error("commit pulse");
  primary_word_a: assert property (instr_valid_q && instr_slot_q == 3'h0
    |-> {instr_ext_q, instr_code_q} == $past(primary_instruction_slot, 2))
    else $error("primary word");
  slot_order_a: assert property (extra_issue_s |->
    instr_slot_q > $past(instr_slot_q)) else $error("slot order");
  skip_slot_a: assert property (extra_issue_s |->
    {instr_ext_q, instr_code_q} != 16'hFFFF) else $error("skip ran");
  flag_clear_a: assert property (drop_s |=> !execution_complete_flag)
    else $error("flag held");
endmodule : rrc_top_checker
bind rrc_top rrc_top_checker #(.SEL_W(SEL_W)) u_chk (
  .clk_sys, .rst_b, .fault_record_selector, .pid_target_value,
  .primary_instruction_slot, .execute_request_bit,
  .nonvolatile_write_request, .torque_source_selection, .instr_valid_q,
  .instr_code_q, .instr_ext_q, .instr_slot_q, .execution_complete_flag,
  .fault_index_q, .fault_zero_q, .pid_target_q, .torque_value_ram_param,
  .torque_value_eeprom_param, .torque_nv_commit_q);
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the command unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, execute_request_bit, volatile_write_request;
  logic        nonvolatile_write_request, torque_control_active, instr_done;
  logic [15:0] fault_record_selector, pid_target_value, pid_feedback_value;
  logic [15:0] pid_error_value, torque_command_or_limit, set_frequency_word;
  logic [15:0] slot_w [6];
  logic [15:0] op_w [6];
  logic [7:0]  torque_source_selection, torque_limit_input_method;
  logic [7:0]  frequency_sign_selection, pid_action_selection;
  logic [7:0]  pid_target_input_selection, pid_feedback_input_selection;
  logic        instr_valid_q, execution_complete_flag, fault_zero_q;
  logic        torque_is_limit_q, torque_nv_commit_q, freq_reverse_q;
  logic [7:0]  instr_code_q, instr_ext_q;
  logic [2:0]  instr_slot_q;
  logic [3:0]  fault_index_q, exec_delay;
  logic [15:0] instr_operand_q, pid_target_q, pid_feedback_q, pid_error_q;
  logic [15:0] torque_value_ram_param, torque_value_eeprom_param;
  logic [15:0] freq_magnitude_q;
  logic        freq_nv_commit_q;
  logic [7:0]  fsel [4] = '{8'h00, 8'h09, 8'h0A, 8'hFF};
  int          mismatches, tests_run, cyc, nv_seen, k;
  int          seen [$];

  rrc_top #(.SEL_W(8)) DUT (
    .clk_sys, .rst_b, .fault_record_selector, .pid_target_value,
    .pid_feedback_value, .pid_error_value, .torque_command_or_limit,
    .set_frequency_word, .primary_instruction_slot(slot_w[0]),
    .primary_operand_slot(op_w[0]), .extra_instruction_slot_a(slot_w[1]),
    .extra_operand_slot_a(op_w[1]), .extra_instruction_slot_b(slot_w[2]),
    .extra_operand_slot_b(op_w[2]), .extra_instruction_slot_c(slot_w[3]),
    .extra_operand_slot_c(op_w[3]), .extra_instruction_slot_d(slot_w[4]),
    .extra_operand_slot_d(op_w[4]), .extra_instruction_slot_e(slot_w[5]),
    .extra_operand_slot_e(op_w[5]), .execute_request_bit,
    .volatile_write_request, .nonvolatile_write_request,
    .torque_source_selection, .torque_limit_input_method,
    .frequency_sign_selection, .pid_action_selection,
    .pid_target_input_selection, .pid_feedback_input_selection,
    .torque_control_active, .instr_done, .instr_valid_q, .instr_code_q,
    .instr_ext_q, .instr_operand_q, .instr_slot_q, .execution_complete_flag,
    .fault_index_q, .fault_zero_q, .pid_target_q, .pid_feedback_q,
    .pid_error_q, .torque_value_ram_param, .torque_value_eeprom_param,
    .torque_is_limit_q, .torque_nv_commit_q, .freq_magnitude_q,
    .freq_reverse_q, .freq_nv_commit_q);
  rrc_exec_model u_exec (.clk_sys, .rst_b, .instr_valid_q,
    .resp_delay(exec_delay), .instr_done);

  // =====================================================================
  // Helpers
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Settle past the edge so updates have landed
  task automatic chk(input string what, input logic [16:0] got,
                     input logic [16:0] exp);
    #1;
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request falls between writes: five cycles per call
  task automatic wr(input logic is_nv, input logic [15:0] tq, fq);
    tick();
    torque_command_or_limit <= tq;
    set_frequency_word <= fq;
    volatile_write_request <= !is_nv;
    nonvolatile_write_request <= is_nv;
    tick();
    volatile_write_request <= 1'b0;
    nonvolatile_write_request <= 1'b0;
    tick(3);
  endtask : wr
  task automatic tq_chk(input logic [15:0] e, input logic lim,
                        input logic [15:0] fm, input logic rev);
    chk("torque ram", torque_value_ram_param, e);
    chk("torque eeprom", torque_value_eeprom_param, e);
    chk("torque limit", torque_is_limit_q, lim);
    chk("freq", freq_magnitude_q, fm);
    chk("reverse", freq_reverse_q, rev);
  endtask : tq_chk
  task automatic batch();
    seen.delete();
    tick();
    execute_request_bit <= 1'b1;
    for (int n = 0; n < 200 && execution_complete_flag !== 1'b1; n++)
      tick();
    tick(3);
    chk("flag", execution_complete_flag, 1'b1);
    k = 0;
    foreach (slot_w[i])
      if (i == 0 || slot_w[i] !== 16'hFFFF) begin
        chk("slot order", seen[k], i);
        k++;
      end
    chk("slot count", seen.size(), k);
    tick();
    execute_request_bit <= 1'b0;
    tick(2);
    chk("flag dropped", execution_complete_flag, 1'b0);
  endtask : batch
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // =====================================================================
  // Clock, watchdog and issue monitor
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      test_done();
    end
  end
  always @(negedge clk_sys) begin
    if (torque_nv_commit_q === 1'b1)
      nv_seen++;
    if (freq_nv_commit_q === 1'b1)
      nv_seen++;
    if (instr_valid_q === 1'b1) begin
      seen.push_back(int'(instr_slot_q));
      chk("word", {instr_ext_q, instr_code_q}, slot_w[instr_slot_q]);
      chk("operand", instr_operand_q, op_w[instr_slot_q]);
    end
  end

  // =====================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    {fault_record_selector, pid_target_value, pid_feedback_value} = '0;
    {pid_error_value, torque_command_or_limit, set_frequency_word} = '0;
    slot_w = '{default: 16'hFFFF};
    op_w = '{default: 16'h0000};
    {execute_request_bit, volatile_write_request} = 2'h0;
    {nonvolatile_write_request, torque_control_active} = 2'h0;
    {torque_source_selection, torque_limit_input_method} = 16'h0300;
    {frequency_sign_selection, pid_action_selection} = 16'h0001;
    {pid_target_input_selection, pid_feedback_input_selection} = 16'h0505;
    exec_delay = 4'h1;
    tick(8);
    rst_b <= 1'b1;
    tick();
    chk("reset pid", pid_target_q, 16'h0000);
    foreach (fsel[i]) begin
      tick();
      fault_record_selector <= {fsel[i], 8'h00};
      tick(2);
      chk("fault zero", fault_zero_q, fsel[i] > 8'h09);
      if (fsel[i] < 8'h0A)
        chk("fault index", fault_index_q, fsel[i][3:0]);
    end
    // Full scale PID, then just past it
    tick();
    pid_target_value <= 16'h2710;
    pid_feedback_value <= 16'h0001;
    pid_error_value <= 16'hD8F0;
    tick(3);
    pid_target_value <= 16'h2711;
    pid_feedback_value <= 16'h2711;
    pid_error_value <= 16'hD8EF;
    tick(3);
    chk("pid target", pid_target_q, 16'h2710);
    chk("pid feedback", pid_feedback_q, 16'h0001);
    chk("pid error", pid_error_q, 16'hD8F0);
    tick();
    pid_action_selection <= 8'h00;
    pid_target_value <= 16'h0005;
    tick(3);
    chk("pid disabled", pid_target_q, 16'h2710);
    // Torque command edges, then absolute limit mode
    torque_control_active <= 1'b1;
    wr(1'b0, 16'h0FA0, 16'hE678);
    tq_chk(16'h0FA0, 1'b0, 16'hE678, 1'b0);
    wr(1'b0, 16'h0FA1, 16'hE679);
    tq_chk(16'h0FA0, 1'b0, 16'hE678, 1'b0);
    frequency_sign_selection <= 8'h01;
    wr(1'b1, 16'hF060, 16'hFF9C);
    tq_chk(16'hF060, 1'b0, 16'h0064, 1'b1);
    chk("nv pulses", nv_seen, 2);
    torque_control_active <= 1'b0;
    torque_source_selection <= 8'h05;
    torque_limit_input_method <= 8'h02;
    wr(1'b0, 16'h7FFF, 16'h8000);
    tq_chk(16'h7FFF, 1'b1, 16'h8000, 1'b1);
    wr(1'b0, 16'hFFFF, 16'h0064);
    tq_chk(16'h7FFF, 1'b1, 16'h0064, 1'b0);
    torque_limit_input_method <= 8'h00;
    wr(1'b0, 16'h0007, 16'h0064);
    chk("no limit mode", torque_value_ram_param, 16'h7FFF);
    // Batch with skips, then primary only, slow executor
    slot_w <= '{16'h0200, 16'h1234, 16'hFFFF, 16'hAB05, 16'hFFFF, 16'h0007};
    op_w <= '{16'h0000, 16'h0011, 16'h0000, 16'h0033, 16'h0000, 16'h0000};
    batch();
    slot_w <= '{default: 16'hFFFF};
    exec_delay <= 4'h4;
    batch();
    test_done();
  end
endmodule : tb
`default_nettype wire
